// ==== src/ssl_core.sv ====
`timescale 1ns/1ps
// Contract
// - Stack starts high and grows downward; last stored is first retrieved.
// - Any register except the program counter may act as stack pointer.
// - Calls, interrupts and traps implicitly use register 6 as stack pointer.
// - System stack holds whole words; other stacks may hold bytes.
// - Push decrements the pointer first, then writes at new address.
// - Pop reads at pointer, then increments the pointer.
// - Pointer addresses the newest item; next lower location is free.
// - Word items take two byte addresses, byte items take one.
// - Call pushes linkage register, copies return address into it, then jumps.
// - Call with program counter as link pushes return address, loads entry.
// - Return recovers the linkage saved by the matching call.
// - Return copies register to program counter, then pops register.
// - Trap or interrupt saves program counter and status word on stack.
// - Interrupt pushes status word first, program counter second.
// - New program counter from first vector word, status from next.
// - Interrupt return pops program counter, then status word.
// - Nesting is unlimited until the stack leaves its region; code only flags overflow_o below SP_LIMIT and keeps going.
// - Relative address is program counter plus fixed displacement.
module ssl_core
  import ssl_pkg::*;
#(
  parameter logic [15:0] SP_LIMIT = SP_LIMIT_DEF
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 cmd_valid_i,
  input  wire ssl_pkg::ssl_cmd_t    cmd_i,
  input  wire logic                 mem_ack_i,
  input  wire logic [15:0]          mem_rdata_i,
  output logic                      cmd_ready_o,
  output logic                      done_o,
  output logic      [15:0]          result_o,
  output ssl_pkg::ssl_mem_req_t     mem_o,
  output logic      [15:0]          pc_o,
  output logic      [15:0]          psw_o,
  output logic      [15:0]          sys_sp_o,
  output logic                      overflow_o
);
  import ssl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ssl_state_t       st;
    logic [7:0][15:0] regs;
    logic [15:0]      psw;
    logic [2:0]       rsel;
    logic             byte_op;
    logic [15:0]      data;
    logic [15:0]      tmp;
    ssl_mem_req_t     mem;
    logic             done;
    logic [15:0]      result;
    logic             ovf;
    logic             rdy;
  } ssl_core_t;

  ssl_core_t cur_ff;
  ssl_core_t nxt_cur;
  logic [15:0] step_in;
  logic [15:0] step_out;
  logic        step_byte;
  logic        step_sys;
  logic        step_dec;
  ssl_step u_step (
    .ptr_i  (step_in),
    .byte_i (step_byte),
    .sys_i  (step_sys),
    .dec_i  (step_dec),
    .ptr_o  (step_out)
  );
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    step_in      = cur_ff.regs[SYS_SP_IDX];
    step_byte    = 1'b0;
    step_sys     = 1'b1;
    step_dec     = 1'b1;
    case (cur_ff.st)
      SSL_ST_IDLE: begin
        if (cmd_valid_i) begin
          nxt_cur.rsel    = cmd_i.rsel;
          nxt_cur.byte_op = cmd_i.byte_op;
          nxt_cur.data    = cmd_i.data;
          case (cmd_i.op)
            SSL_OP_PUSH: begin
              if (cmd_i.rsel != PC_IDX) begin
                step_in   = cur_ff.regs[cmd_i.rsel];
                step_byte = cmd_i.byte_op;
                step_sys  = (cmd_i.rsel == SYS_SP_IDX);
                nxt_cur.regs[cmd_i.rsel] = step_out;
                nxt_cur.mem = '{1'b1, 1'b1, step_byte && !step_sys, step_out, cmd_i.data};
                nxt_cur.st  = SSL_ST_PUSH;
              end else begin
                nxt_cur.done = 1'b1;
              end
            end
            SSL_OP_POP: begin
              if (cmd_i.rsel != PC_IDX) begin
                nxt_cur.mem = '{1'b1, 1'b0, cmd_i.byte_op && (cmd_i.rsel != SYS_SP_IDX),
                                cur_ff.regs[cmd_i.rsel], 16'h0000};
                nxt_cur.st  = SSL_ST_POP;
              end else begin
                nxt_cur.done = 1'b1;
              end
            end
            SSL_OP_JSR: begin
              nxt_cur.regs[SYS_SP_IDX] = step_out;
              nxt_cur.mem = '{1'b1, 1'b1, 1'b0, step_out, cur_ff.regs[cmd_i.rsel]};
              nxt_cur.st  = SSL_ST_JSRP;
            end
            SSL_OP_RTS: begin
              nxt_cur.regs[PC_IDX] = cur_ff.regs[cmd_i.rsel];
              nxt_cur.mem = '{1'b1, 1'b0, 1'b0, cur_ff.regs[SYS_SP_IDX], 16'h0000};
              nxt_cur.st  = SSL_ST_RTSP;
            end
            SSL_OP_INT: begin
              nxt_cur.regs[SYS_SP_IDX] = step_out;
              nxt_cur.mem = '{1'b1, 1'b1, 1'b0, step_out, cur_ff.psw};
              nxt_cur.st  = SSL_ST_IPSW;
            end
            SSL_OP_RTI: begin
              nxt_cur.mem = '{1'b1, 1'b0, 1'b0, cur_ff.regs[SYS_SP_IDX], 16'h0000};
              nxt_cur.st  = SSL_ST_RPC;
            end
            SSL_OP_PCR: begin
              nxt_cur.result = 16'(cur_ff.regs[PC_IDX] + cmd_i.data);
              nxt_cur.done   = 1'b1;
            end
            default: nxt_cur.done = 1'b1;
          endcase
        end
      end
      SSL_ST_PUSH, SSL_ST_JSRP: begin
        if (mem_ack_i) begin
          nxt_cur.mem.req = 1'b0;
          if (cur_ff.st == SSL_ST_JSRP) begin
            nxt_cur.regs[cur_ff.rsel] = cur_ff.regs[PC_IDX];
            nxt_cur.regs[PC_IDX]      = cur_ff.data;
          end
          nxt_cur.done = 1'b1;
          nxt_cur.st   = SSL_ST_IDLE;
        end
      end
      SSL_ST_POP: begin
        step_in   = cur_ff.regs[cur_ff.rsel];
        step_byte = cur_ff.byte_op;
        step_sys  = (cur_ff.rsel == SYS_SP_IDX);
        step_dec  = 1'b0;
        if (mem_ack_i) begin
          nxt_cur.mem.req           = 1'b0;
          nxt_cur.result            = mem_rdata_i;
          nxt_cur.regs[cur_ff.rsel] = step_out;
          nxt_cur.done              = 1'b1;
          nxt_cur.st                = SSL_ST_IDLE;
        end
      end
      SSL_ST_RTSP: begin
        step_dec = 1'b0;
        if (mem_ack_i) begin
          nxt_cur.mem.req           = 1'b0;
          nxt_cur.regs[SYS_SP_IDX]  = step_out;
          nxt_cur.regs[cur_ff.rsel] = mem_rdata_i;
          nxt_cur.done              = 1'b1;
          nxt_cur.st                = SSL_ST_IDLE;
        end
      end
      SSL_ST_IPSW: begin
        if (mem_ack_i) begin
          nxt_cur.regs[SYS_SP_IDX] = step_out;
          nxt_cur.mem = '{1'b1, 1'b1, 1'b0, step_out, cur_ff.regs[PC_IDX]};
          nxt_cur.st  = SSL_ST_IPC;
        end
      end
      SSL_ST_IPC: begin
        if (mem_ack_i) begin
          nxt_cur.mem = '{1'b1, 1'b0, 1'b0, cur_ff.data, 16'h0000};
          nxt_cur.st  = SSL_ST_VPC;
        end
      end
      SSL_ST_VPC: begin
        if (mem_ack_i) begin
          nxt_cur.tmp = mem_rdata_i;
          nxt_cur.mem = '{1'b1, 1'b0, 1'b0, 16'(cur_ff.data + WORD_STEP), 16'h0000};
          nxt_cur.st  = SSL_ST_VPSW;
        end
      end
      SSL_ST_VPSW: begin
        if (mem_ack_i) begin
          nxt_cur.mem.req      = 1'b0;
          nxt_cur.regs[PC_IDX] = cur_ff.tmp;
          nxt_cur.psw          = mem_rdata_i;
          nxt_cur.done         = 1'b1;
          nxt_cur.st           = SSL_ST_IDLE;
        end
      end
      SSL_ST_RPC, SSL_ST_RPSW: begin
        step_dec = 1'b0;
        if (mem_ack_i) begin
          nxt_cur.regs[SYS_SP_IDX] = step_out;
          if (cur_ff.st == SSL_ST_RPC) begin
            nxt_cur.regs[PC_IDX] = mem_rdata_i;
            nxt_cur.mem.addr     = step_out;
            nxt_cur.st           = SSL_ST_RPSW;
          end else begin
            nxt_cur.psw     = mem_rdata_i;
            nxt_cur.mem.req = 1'b0;
            nxt_cur.done    = 1'b1;
            nxt_cur.st      = SSL_ST_IDLE;
          end
        end
      end
      default: nxt_cur.st = SSL_ST_IDLE;
    endcase
    nxt_cur.ovf = (nxt_cur.regs[SYS_SP_IDX] < SP_LIMIT);
    nxt_cur.rdy = (nxt_cur.st == SSL_ST_IDLE);
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cur_ff                  <= '0;
      cur_ff.rdy              <= 1'b1;
      cur_ff.regs             <= {8{REG_RST_VAL}};
      cur_ff.regs[SYS_SP_IDX] <= SP_RST_VAL;
      cur_ff.regs[PC_IDX]     <= PC_RST_VAL;
      cur_ff.psw              <= PSW_RST_VAL;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cmd_ready_o = cur_ff.rdy;
  assign done_o      = cur_ff.done;
  assign result_o    = cur_ff.result;
  assign mem_o       = cur_ff.mem;
  assign pc_o        = cur_ff.regs[PC_IDX];
  assign psw_o       = cur_ff.psw;
  assign sys_sp_o    = cur_ff.regs[SYS_SP_IDX];
  assign overflow_o  = cur_ff.ovf;
  // ****************************************
  // Checks
  // ****************************************
  property p_push_dec;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_IDLE && cmd_valid_i && cmd_i.op == SSL_OP_PUSH
     && cmd_i.rsel == SYS_SP_IDX) |=> (sys_sp_o == 16'($past(sys_sp_o) - WORD_STEP))
     && mem_o.we && mem_o.addr == sys_sp_o;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not predecrement");
  property p_pop_inc;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_POP && mem_ack_i && cur_ff.rsel == SYS_SP_IDX)
    |=> sys_sp_o == 16'($past(sys_sp_o) + WORD_STEP);
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("pop did not postincrement");
  property p_sp_even;
    @(posedge mclk_i) disable iff (!rst_n_i) $past(sys_sp_o[0]) == 1'b0 |-> !sys_sp_o[0];
  endproperty
  a_sp_even: assert property (p_sp_even) else $error("system pointer went odd");
  property p_int_order;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_IDLE && cmd_valid_i && cmd_i.op == SSL_OP_INT)
    |=> mem_o.wdata == psw_o && mem_o.we;
  endproperty
  a_int_order: assert property (p_int_order) else $error("status not pushed first");
  property p_pcrel;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_IDLE && cmd_valid_i && cmd_i.op == SSL_OP_PCR)
    |=> done_o && result_o == 16'($past(pc_o) + $past(cmd_i.data));
  endproperty
  a_pcrel: assert property (p_pcrel) else $error("relative address wrong");
  property p_jsr_pc;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_JSRP && mem_ack_i) |=> pc_o == $past(cur_ff.data) && done_o;
  endproperty
  a_jsr_pc: assert property (p_jsr_pc) else $error("call did not jump");
  property p_rts_pc;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_IDLE && cmd_valid_i && cmd_i.op == SSL_OP_RTS && cmd_i.rsel != PC_IDX)
    |=> pc_o == $past(cur_ff.regs[cmd_i.rsel]);
  endproperty
  a_rts_pc: assert property (p_rts_pc) else $error("return lost register");
  property p_rti_sp;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cur_ff.st == SSL_ST_RPSW && mem_ack_i) |=> done_o && psw_o == $past(mem_rdata_i)
      && sys_sp_o == 16'($past(sys_sp_o) + WORD_STEP);
  endproperty
  a_rti_sp: assert property (p_rti_sp) else $error("return from interrupt lost status");
  c_jsr: cover property (@(posedge mclk_i) cur_ff.st == SSL_ST_JSRP ##1 done_o);
  c_int: cover property (@(posedge mclk_i) cur_ff.st == SSL_ST_VPSW && mem_ack_i);
  c_rti: cover property (@(posedge mclk_i) cur_ff.st == SSL_ST_RPSW && mem_ack_i);
  c_ovf: cover property (@(posedge mclk_i) overflow_o);
endmodule

// ==== src/ssl_pkg.sv ====
package ssl_pkg;

  // ****************************************
  // Widths and register numbers
  // ****************************************
  localparam int unsigned DW           = 16;
  localparam logic [2:0]  SYS_SP_IDX   = 3'h6;
  localparam logic [2:0]  PC_IDX       = 3'h7;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam logic [15:0] SP_RST_VAL   = 16'h1000;
  localparam logic [15:0] PC_RST_VAL   = 16'h0000;
  localparam logic [15:0] PSW_RST_VAL  = 16'h0000;
  localparam logic [15:0] REG_RST_VAL  = 16'h0000;
  localparam logic [15:0] SP_LIMIT_DEF = 16'h0400;

  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [2:0] {
    SSL_OP_PUSH = 3'h0,
    SSL_OP_POP  = 3'h1,
    SSL_OP_JSR  = 3'h2,
    SSL_OP_RTS  = 3'h3,
    SSL_OP_INT  = 3'h4,
    SSL_OP_RTI  = 3'h5,
    SSL_OP_PCR  = 3'h6
  } ssl_op_t;

  typedef struct packed {
    ssl_op_t     op;
    logic [2:0]  rsel;
    logic        byte_op;
    logic [15:0] data;
  } ssl_cmd_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ssl_mem_req_t;

  typedef enum logic [3:0] {
    SSL_ST_IDLE  = 4'h0,
    SSL_ST_PUSH  = 4'h1,
    SSL_ST_POP   = 4'h2,
    SSL_ST_JSRP  = 4'h3,
    SSL_ST_RTSP  = 4'h4,
    SSL_ST_IPSW  = 4'h5,
    SSL_ST_IPC   = 4'h6,
    SSL_ST_VPC   = 4'h7,
    SSL_ST_VPSW  = 4'h8,
    SSL_ST_RPC   = 4'h9,
    SSL_ST_RPSW  = 4'ha,
    SSL_ST_WAIT  = 4'hb
  } ssl_state_t;

endpackage

// ==== src/ssl_step.sv ====
`timescale 1ns/1ps
// Pointer step: byte or word, system pointer always even
module ssl_step
  import ssl_pkg::*;
(
  input  wire logic [15:0] ptr_i,
  input  wire logic        byte_i,
  input  wire logic        sys_i,
  input  wire logic        dec_i,
  output logic      [15:0] ptr_o
);
  logic [15:0] step;

  always_comb begin
    step  = (byte_i && !sys_i) ? BYTE_STEP : WORD_STEP;
    ptr_o = dec_i ? 16'(ptr_i - step) : 16'(ptr_i + step);
  end
endmodule

// ==== testbench/ssl_mem_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Stack memory, answers after 2 to 5 cycles
// ****************************************
module ssl_mem_model
  import ssl_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire ssl_pkg::ssl_mem_req_t mem_i,
  output logic                       ack_o,
  output logic      [15:0]           rdata_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] hi_addr;
  int          wait_cnt;

  assign hi_addr = mem_i.addr + 16'h0001;

  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ 8'h5a;
    end
  end

  always @(posedge mclk_i) begin
    // Read lines toggle outside the answer so stale data never looks valid
    rdata_o <= rst_n_i ? ~rdata_o : 16'h0000;
    if (ack_o || !rst_n_i || !mem_i.req) begin
      ack_o    <= 1'b0;
      wait_cnt <= -1;
    end else if (wait_cnt < 0) begin
      wait_cnt <= $urandom_range(3, 0);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else begin
      ack_o <= 1'b1;
      if (!mem_i.we) begin
        rdata_o <= {mem[hi_addr], mem[mem_i.addr]};
      end else begin
        mem[mem_i.addr] <= mem_i.wdata[7:0];
        if (!mem_i.byte_en) begin
          mem[hi_addr] <= mem_i.wdata[15:8];
        end
      end
    end
  end
endmodule

// ==== testbench/stack_subroutine_linkage_tb.sv ====
`timescale 1ns/1ps
module stack_subroutine_linkage_tb;
  import ssl_pkg::*;
  localparam logic [15:0] LIM = 16'h0ff0;
  logic         mclk_i;
  logic         rst_n_i;
  logic         cmd_valid_i;
  ssl_cmd_t     cmd_i;
  logic         mem_ack_i;
  logic [15:0]  mem_rdata_i;
  logic         cmd_ready_o;
  logic         done_o;
  logic [15:0]  result_o;
  ssl_mem_req_t mem_o;
  logic [15:0]  pc_o;
  logic [15:0]  psw_o;
  logic [15:0]  sys_sp_o;
  logic         overflow_o;
  int           err_count;
  int           compares;
  logic [15:0]  xr [0:7];
  logic [15:0]  xpsw;
  logic [15:0]  xres;
  logic [7:0]   sh [0:65535];
  ssl_mem_req_t xq [$];
  ssl_mem_req_t ex;
  ssl_cmd_t     c;

  ssl_core #(.SP_LIMIT(LIM)) ssl_core_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .result_o(result_o), .mem_o(mem_o), .pc_o(pc_o), .psw_o(psw_o),
    .sys_sp_o(sys_sp_o), .overflow_o(overflow_o));
  ssl_mem_model ssl_mem_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mem_i(mem_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ****************************************
  // Checking and prediction
  // ****************************************
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] rd(logic [15:0] a);
    return {sh[a + 16'h0001], sh[a]};
  endfunction

  function automatic ssl_cmd_t mk(ssl_op_t op, logic [2:0] r, logic b, logic [15:0] d);
    return '{op: op, rsel: r, byte_op: b, data: d};
  endfunction

  task automatic acc(logic we, logic bt, logic [15:0] a, logic [15:0] d);
    xq.push_back('{req: 1'b1, we: we, byte_en: bt, addr: a, wdata: d});
    if (we) begin
      sh[a] = d[7:0];
      if (!bt) begin
        sh[a + 16'h0001] = d[15:8];
      end
    end
  endtask

  task automatic predict(ssl_cmd_t k);
    logic [15:0] st;
    st = (k.byte_op && k.rsel != SYS_SP_IDX) ? BYTE_STEP : WORD_STEP;
    case (k.op)
      SSL_OP_PUSH: if (k.rsel != PC_IDX) begin
        xr[k.rsel] = xr[k.rsel] - st;
        acc(1'b1, st == BYTE_STEP, xr[k.rsel], k.data);
      end
      SSL_OP_POP: if (k.rsel != PC_IDX) begin
        acc(1'b0, st == BYTE_STEP, xr[k.rsel], 16'h0000);
        xres = rd(xr[k.rsel]);
        xr[k.rsel] = xr[k.rsel] + st;
      end
      SSL_OP_JSR: begin
        xr[6] = xr[6] - WORD_STEP;
        acc(1'b1, 1'b0, xr[6], xr[k.rsel]);
        xr[k.rsel] = xr[7];
        xr[7] = k.data;
      end
      SSL_OP_RTS: begin
        xr[7] = xr[k.rsel];
        acc(1'b0, 1'b0, xr[6], 16'h0000);
        xr[k.rsel] = rd(xr[6]);
        xr[6] = xr[6] + WORD_STEP;
      end
      SSL_OP_INT: begin
        acc(1'b1, 1'b0, xr[6] - 16'h0002, xpsw);
        acc(1'b1, 1'b0, xr[6] - 16'h0004, xr[7]);
        xr[6] = xr[6] - 16'h0004;
        acc(1'b0, 1'b0, k.data, 16'h0000);
        acc(1'b0, 1'b0, k.data + 16'h0002, 16'h0000);
        xr[7] = rd(k.data);
        xpsw = rd(k.data + 16'h0002);
      end
      SSL_OP_RTI: begin
        acc(1'b0, 1'b0, xr[6], 16'h0000);
        acc(1'b0, 1'b0, xr[6] + 16'h0002, 16'h0000);
        xr[7] = rd(xr[6]);
        xpsw = rd(xr[6] + 16'h0002);
        xr[6] = xr[6] + 16'h0004;
      end
      default: xres = xr[7] + k.data;
    endcase
  endtask

  task automatic run(ssl_cmd_t k);
    int n;
    predict(k);
    @(negedge mclk_i);
    cmd_i = k;
    cmd_valid_i = 1'b1;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    check("done", n < 100, 1'b1);
    @(negedge mclk_i);
    check("pc", pc_o, xr[7]);
    check("psw", psw_o, xpsw);
    check("sp", sys_sp_o, xr[6]);
    check("overflow", overflow_o, xr[6] < LIM);
    check("pending", xq.size(), 0);
    if ((k.op == SSL_OP_POP && k.rsel != PC_IDX) || k.op == SSL_OP_PCR) begin
      check("result", k.byte_op ? result_o[7:0] : result_o, k.byte_op ? xres[7:0] : xres);
    end
  endtask

  always @(posedge mclk_i) begin
    if (rst_n_i && mem_o.req && mem_ack_i) begin
      ex = (xq.size() > 0) ? xq.pop_front() : '0;
      check("access", {mem_o.req, mem_o.we, mem_o.byte_en, mem_o.addr},
        {ex.req, ex.we, ex.byte_en, ex.addr});
      if (ex.we) begin
        check("wdata", ex.byte_en ? mem_o.wdata[7:0] : mem_o.wdata,
          ex.byte_en ? ex.wdata[7:0] : ex.wdata);
      end
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    #500000;
    err_count++;
    give_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    err_count = 0;
    compares = 0;
    xpsw = PSW_RST_VAL;
    xres = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      xr[i] = REG_RST_VAL;
    end
    xr[6] = SP_RST_VAL;
    xr[7] = PC_RST_VAL;
    for (int a = 0; a < 65536; a++) begin
      sh[a] = a[7:0] ^ 8'h5a;
    end
    void'($urandom(32'hcce21e9a));
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check("reset", {cmd_ready_o, done_o, sys_sp_o, pc_o}, {2'b10, SP_RST_VAL, PC_RST_VAL});
    run(mk(SSL_OP_PCR, 3'h0, 1'b0, 16'h0010));
    run(mk(SSL_OP_JSR, 3'h7, 1'b0, 16'h2000));
    run(mk(SSL_OP_JSR, 3'h5, 1'b0, 16'h3000));
    run(mk(SSL_OP_PCR, 3'h0, 1'b0, 16'hfff0));
    run(mk(SSL_OP_INT, 3'h0, 1'b0, 16'h0100));
    run(mk(SSL_OP_INT, 3'h0, 1'b0, 16'h0104));
    run(mk(SSL_OP_INT, 3'h0, 1'b0, 16'h0108));
    run(mk(SSL_OP_PUSH, 3'h6, 1'b0, 16'h1234));
    run(mk(SSL_OP_POP, 3'h6, 1'b0, 16'h0000));
    for (int i = 0; i < 3; i++) begin
      run(mk(SSL_OP_RTI, 3'h0, 1'b0, 16'h0000));
    end
    run(mk(SSL_OP_RTS, 3'h5, 1'b0, 16'h0000));
    run(mk(SSL_OP_RTS, 3'h7, 1'b0, 16'h0000));
    run(mk(SSL_OP_PUSH, 3'h3, 1'b1, 16'h00a5));
    run(mk(SSL_OP_PUSH, 3'h3, 1'b1, 16'h003c));
    run(mk(SSL_OP_POP, 3'h3, 1'b1, 16'h0000));
    run(mk(SSL_OP_PUSH, 3'h6, 1'b1, 16'h0077));
    run(mk(SSL_OP_POP, 3'h6, 1'b1, 16'h0000));
    run(mk(SSL_OP_PUSH, 3'h7, 1'b0, 16'hbeef));
    run(mk(SSL_OP_POP, 3'h7, 1'b0, 16'h0000));
    for (int i = 0; i < 250; i++) begin
      c = mk(ssl_op_t'($urandom_range(6, 0)), 3'($urandom), 1'b0, 16'($urandom));
      if (xr[6] >= SP_RST_VAL && (c.op == SSL_OP_RTS || c.op == SSL_OP_RTI)) begin
        c.op = SSL_OP_JSR;
      end
      if (xr[6] < 16'h0e00 && c.op != SSL_OP_RTS && c.op != SSL_OP_PCR) begin
        c.op = SSL_OP_RTI;
      end
      if ((c.op == SSL_OP_JSR || c.op == SSL_OP_RTS) && c.rsel == SYS_SP_IDX) begin
        c.rsel = PC_IDX;
      end
      if (c.op == SSL_OP_POP && c.rsel == SYS_SP_IDX && xr[6] >= SP_RST_VAL) begin
        c.op = SSL_OP_PUSH;
      end
      c.byte_op = (c.op <= SSL_OP_POP && c.rsel < SYS_SP_IDX) ? 1'($urandom) : 1'b0;
      c.data = (c.op == SSL_OP_INT) ? (16'h0100 | {10'h000, c.data[3:0], 2'b00}) : c.data;
      c.data[0] = (c.op == SSL_OP_JSR) ? 1'b0 : c.data[0];
      run(c);
    end
    give_verdict();
  end
endmodule
